// ==== bench/ccdfe_tgen_model.sv ====
// timing generator stand-in: converter clock and sample stream.
// assumes the core clock; samples change only at converter falls.
module ccdfe_tgen_model (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic [9:0] base_i,
  output logic conv_clk_o,
  output logic [9:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r = 2'h0;
  initial sample_o = 10'h000;
  // two cycles per phase so the core always sees each half
  assign conv_clk_o = ph_r[1];
  always @(posedge clk_i) begin
    ph_r <= ph_r + 2'h1;
    // new value at the fall only, steady around the sampling rise
    if (ph_r == 2'h3) sample_o <= hold_i ? base_i : sample_o + 10'h03D;
  end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the ccd front end control block.
// assumes ccdfe_pkg and the timing generator model; drives on falling edges.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccdfe_pkg::*;
  typedef struct {int k; logic [9:0] v; int due;} ccdfe_note_t;
  logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, serial_data_in = 1'b0, cs_n = 1'b1;
  logic clamp_n = 1'b1, oe_n = 1'b0, hold = 1'b0, conv, conv_q = 1'b0, dat_on = 1'b0;
  logic [9:0] base = 10'h000, sample, data, v, g, hist[$];
  logic data_oe, st1, st2, stby, xref, p_oe, n_oe, pga, m_oe, m_crs;
  logic [8:0] gain, coarse, fine;
  logic [7:0] dac1, dac2;
  logic [3:0] bias;
  logic [9:0] obs[13];
  int errors = 0, total_checks = 0, cyc = 0, e, f1;
  ccdfe_note_t qr[$], qd[$];
  string nm[13] = '{"data", "gain", "dac1", "dac2", "bias", "tpins", "xref", "mon",
    "data_oe", "stby", "data_low", "coarse", "fine"};
  always #2.5 clk = ~clk;
  assign obs = '{data, {1'b0, gain}, {2'b00, dac1}, {2'b00, dac2}, {6'h00, bias},
    {7'h00, pga, n_oe, p_oe}, {9'h000, xref}, {8'h00, m_crs, m_oe}, {9'h000, data_oe},
    {7'h00, stby, st1, st2}, {1'b0, data[8:0]}, {1'b0, coarse}, {1'b0, fine}};
  ccdfe_tgen_model tgen (.clk_i(clk), .hold_i(hold), .base_i(base), .conv_clk_o(conv),
    .sample_o(sample));
  ccdfe_ctrl DUT (.CORE_CLK_I(clk), .RESET_I(rst), .SCLK_I(sclk), .SERIAL_DATA_IN_I(serial_data_in),
    .CS_N_I(cs_n), .CONVERTER_CLOCK_I(conv), .ADC_SAMPLE_I(sample),
    .BLACK_CAL_CLAMP_N_I(clamp_n), .OE_N_I(oe_n), .DATA_O(data), .DATA_OE_O(data_oe),
    .PGA_GAIN_CODE_O(gain), .USER_DAC1_CODE_O(dac1), .USER_DAC2_CODE_O(dac2),
    .USER_DAC1_STANDBY_O(st1), .USER_DAC2_STANDBY_O(st2), .STANDBY_O(stby),
    .COARSE_OFFSET_O(coarse), .FINE_OFFSET_O(fine), .BIAS_CURRENT_CODE_O(bias),
    .TEST_OUT_POS_OE_O(p_oe), .TEST_OUT_NEG_OE_O(n_oe), .TEST_OUT_PGA_SEL_O(pga),
    .EXTERNAL_REFERENCE_SELECT_O(xref), .OFFSET_MONITOR_PIN_OE_O(m_oe),
    .OFFSET_MONITOR_COARSE_SEL_O(m_crs));
  task automatic note(int k, logic [9:0] x, int d);
    qr.push_back('{k, x, cyc + d});
  endtask
  task automatic check(string n, logic [9:0] seen, logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // nb below 16 sends a short frame that must be dropped
  task automatic wr(logic [3:0] a, logic [9:0] x, int nb = 16);
    logic [15:0] f;
    f = {2'($urandom), a, x};
    @(negedge clk) cs_n = 1'b0;
    for (int i = 15; i > 15 - nb; i--) begin
      @(negedge clk) sclk = 1'b0;
      serial_data_in = f[i];
      @(negedge clk) sclk = 1'b1;
    end
    @(negedge clk) sclk = 1'b0;
    cs_n = 1'b1;
    @(negedge clk);
  endtask
  // one clamp pulse per line, well clear of line edges
  task automatic line();
    repeat (8) @(negedge clk);
    clamp_n = 1'b0;
    repeat (40) @(negedge clk);
    clamp_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    conv_q <= conv;
    if (conv && !conv_q) hist.push_back(sample);
    // a fall shows the sample taken four rises before the latest
    if (!conv && conv_q && dat_on && hist.size() > 4) qd.push_back('{0, hist[$-4], cyc + 2});
  end
  always @(negedge clk) begin
    while (qd.size() > 0 && qd[0].due <= cyc) begin
      check("data", data, qd[0].v);
      qd.delete(0);
    end
    while (qr.size() > 0 && qr[0].due <= cyc) begin
      check(nm[qr[0].k], obs[qr[0].k], qr[0].v);
      qr.delete(0);
    end
  end
  initial begin
    wait (cyc >= 8000);
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(58033));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    note(4, 10'h00A, 2);
    note(5, 10'h000, 2);
    note(6, 10'h000, 2);
    note(7, 10'h000, 2);
    note(8, 10'h001, 2);
    repeat (30) @(negedge clk);
    dat_on = 1'b1;
    for (int t = 0; t < 16; t++) begin
      v = {4'($urandom), 2'(t >> 2), 2'($urandom), 2'(t)};
      wr(ADDR_TEST, v);
      note(4, 10'(v[9:6]), 3);
      note(5, 10'({v[5] & v[4], v[5], v[5]}), 3);
      note(6, 10'(v[3]), 3);
      note(7, 10'({v[1] & v[0], v[1]}), 3);
    end
    for (int t = 0; t < 4; t++) begin
      g = (t == 0) ? 10'h000 : (t == 1) ? 10'h17F : (t == 2) ? 10'($urandom_range(382)) : 10'h3FF;
      wr(ADDR_GAIN, g);
      note(1, (g[8:0] > GAIN_MAX) ? {1'b0, GAIN_MAX} : {1'b0, g[8:0]}, 3);
      v = 10'($urandom);
      wr(4'(ADDR_UDAC1 + t[0]), v);
      note(2 + t[0], {2'b00, v[7:0]}, 3);
      wr(ADDR_CONTROL, {t[0], t[1], t[0], 7'h60});
      note(9, 10'({t[0], t[1], t[0]}), 4);
    end
    wr(ADDR_GAIN, 10'h005, 15);
    note(1, 10'h17F, 3);
    wr(4'h9, 10'h000);
    note(1, 10'h17F, 3);
    oe_n = 1'b1;
    note(8, 10'h000, 2);
    repeat (3) @(negedge clk);
    oe_n = 1'b0;
    note(8, 10'h001, 2);
    dat_on = 1'b0;
    v = 10'($urandom);
    g = 10'($urandom);
    wr(ADDR_COARSE, v);
    wr(ADDR_FINE, g);
    note(11, {1'b0, v[8:0]}, 3);
    note(12, {1'b0, g[8:0]}, 3);
    wr(ADDR_BLACK_CAL, 10'h203);
    note(10, {1'b0, v[8:0]}, 12);
    wr(ADDR_BLACK_CAL, 10'h303);
    note(10, {1'b0, g[8:0]}, 12);
    wr(ADDR_BLACK_CAL, 10'h103);
    repeat (12) @(negedge clk);
    dat_on = 1'b1;
    repeat (40) @(negedge clk);
    dat_on = 1'b0;
    wr(ADDR_CONTROL, 10'h001);
    note(4, 10'h00A, 4);
    note(12, 10'h000, 4);
    hold = 1'b1;
    base = 10'h041 + 10'($urandom_range(126));
    line();
    f1 = 64 - int'(base);
    note(12, 10'({1'b1, 8'(-f1)}), 1);
    wr(ADDR_BLACK_CAL, 10'h303);
    note(0, {2'b11, 8'(-f1)}, 12);
    wr(ADDR_CONTROL, 10'h002);
    wr(ADDR_BLACK_CAL, 10'h018);
    base = 10'h040 + 10'($urandom_range(100));
    line();
    line();
    e = f1 - ((3 * int'(base) * 170) >> 9) + 64;
    note(12, 10'({e < 0, 8'(e < 0 ? -e : e)}), 1);
    repeat (20) @(negedge clk);
    give_verdict();
  end
endmodule

// ==== rtl/ccdfe_ctrl.sv ====
// ccd front end control: serial registers, black level calibration loop,
// converter data path with output select, and test and monitor selects.
// assumes all pins are synchronous to CORE_CLK_I; converter clock is sampled.
module ccdfe_ctrl
  import ccdfe_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic SCLK_I,
  input wire logic SERIAL_DATA_IN_I,
  input wire logic CS_N_I,
  input wire logic CONVERTER_CLOCK_I,
  input wire logic [9:0] ADC_SAMPLE_I,
  input wire logic BLACK_CAL_CLAMP_N_I,
  input wire logic OE_N_I,
  output logic [9:0] DATA_O,
  output logic DATA_OE_O,
  output logic [8:0] PGA_GAIN_CODE_O,
  output logic [7:0] USER_DAC1_CODE_O,
  output logic [7:0] USER_DAC2_CODE_O,
  output logic USER_DAC1_STANDBY_O,
  output logic USER_DAC2_STANDBY_O,
  output logic STANDBY_O,
  output logic [8:0] COARSE_OFFSET_O,
  output logic [8:0] FINE_OFFSET_O,
  output logic [3:0] BIAS_CURRENT_CODE_O,
  output logic TEST_OUT_POS_OE_O,
  output logic TEST_OUT_NEG_OE_O,
  output logic TEST_OUT_PGA_SEL_O,
  output logic EXTERNAL_REFERENCE_SELECT_O,
  output logic OFFSET_MONITOR_PIN_OE_O,
  output logic OFFSET_MONITOR_COARSE_SEL_O
);
  logic rx_wr;
  logic [3:0] rx_addr;
  logic [9:0] rx_data;
  logic soft_rst;
  logic avg_clear;

  ccdfe_serial_rx u_rx (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .sclk_i(SCLK_I),
    .serial_data_in_i(SERIAL_DATA_IN_I),
    .cs_n_i(CS_N_I),
    .wr_o(rx_wr),
    .addr_o(rx_addr),
    .data_o(rx_data)
  );

  assign soft_rst = rx_wr && rx_addr == ADDR_CONTROL && rx_data[CTL_SOFT_RESET];
  assign avg_clear = rx_wr && rx_addr == ADDR_CONTROL && rx_data[CTL_AVG_CLEAR];

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  // configuration registers (offset converters live with the loop)
  logic [9:0] ctl_r, ctl_nxt;
  logic [8:0] gain_r, gain_nxt;
  logic [7:0] udac1_r, udac1_nxt, udac2_r, udac2_nxt;
  logic [9:0] vb_r, vb_nxt, blk_r, blk_nxt, test_r, test_nxt;

  always_comb begin
    ctl_nxt = ctl_r;
    gain_nxt = gain_r;
    udac1_nxt = udac1_r;
    udac2_nxt = udac2_r;
    vb_nxt = vb_r;
    blk_nxt = blk_r;
    test_nxt = test_r;
    if (soft_rst) begin
      ctl_nxt = CONTROL_RST;
      gain_nxt = GAIN_RST;
      udac1_nxt = UDAC_RST;
      udac2_nxt = UDAC_RST;
      vb_nxt = BLACK_TARGET_RST;
      blk_nxt = BLACK_CAL_RST;
      test_nxt = TEST_RST;
    end else if (rx_wr) begin
      unique case (rx_addr)
        // one-shot bits are acted on, not stored
        ADDR_CONTROL: ctl_nxt = {rx_data[9:2], 2'b00};
        // codes past the top of the range saturate at 383
        ADDR_GAIN: gain_nxt = (rx_data[8:0] > GAIN_MAX) ? GAIN_MAX : rx_data[8:0];
        ADDR_UDAC1: udac1_nxt = rx_data[7:0];
        ADDR_UDAC2: udac2_nxt = rx_data[7:0];
        ADDR_BLACK_TARGET: vb_nxt = rx_data;
        ADDR_BLACK_CAL: blk_nxt = rx_data;
        ADDR_TEST: begin
          test_nxt = rx_data;
          test_nxt[TST_RSVD] = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      ctl_r <= CONTROL_RST;
      gain_r <= GAIN_RST;
      udac1_r <= UDAC_RST;
      udac2_r <= UDAC_RST;
      vb_r <= BLACK_TARGET_RST;
      blk_r <= BLACK_CAL_RST;
      test_r <= TEST_RST;
    end else begin
      ctl_r <= ctl_nxt;
      gain_r <= gain_nxt;
      udac1_r <= udac1_nxt;
      udac2_r <= udac2_nxt;
      vb_r <= vb_nxt;
      blk_r <= blk_nxt;
      test_r <= test_nxt;
    end
  end

  chk_write_commit: assert property (rx_wr && !soft_rst && rx_addr == ADDR_BLACK_CAL
    |=> blk_r == $past(rx_data)) else $error("calibration write not applied");
  chk_reserved_zero: assert property (rx_wr && rx_addr == ADDR_TEST
    |=> !test_r[TST_RSVD]) else $error("reserved test bit stored");
  chk_gain_range: assert property (gain_r <= GAIN_MAX)
    else $error("gain code above range");

  // converter data path: sample on rising edge, present on a falling edge
  logic conv_r, conv_nxt, conv_rise, conv_fall;
  logic [9:0] pipe_r [ADC_PIPE_DEPTH];
  logic [9:0] pipe_nxt [ADC_PIPE_DEPTH];
  logic [9:0] data_r, data_nxt;
  logic oe_r, oe_nxt;
  logic flag_r;
  logic [8:0] coarse_r, fine_r;

  assign conv_nxt = CONVERTER_CLOCK_I;
  assign conv_rise = CONVERTER_CLOCK_I && !conv_r;
  assign conv_fall = !CONVERTER_CLOCK_I && conv_r;
  // relies on the timing generator keeping the clock high phase clear of pulses
  assign pipe_nxt[0] = conv_rise ? ADC_SAMPLE_I : pipe_r[0];

  genvar g;
  for (g = 1; g < ADC_PIPE_DEPTH; g++) begin : g_pipe
    assign pipe_nxt[g] = conv_rise ? pipe_r[g-1] : pipe_r[g];
  end

  always_comb begin
    data_nxt = data_r;
    oe_nxt = !OE_N_I;
    if (conv_fall) begin
      unique case (blk_r[BLK_OSEL_MSB:BLK_OSEL_LSB])
        OSEL_COARSE: data_nxt = {flag_r, coarse_r};
        OSEL_FINE: data_nxt = {flag_r, fine_r};
        default: data_nxt = pipe_r[ADC_PIPE_DEPTH-1];
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      conv_r <= 1'b0;
      data_r <= 10'h000;
      oe_r <= 1'b0;
      for (int i = 0; i < ADC_PIPE_DEPTH; i++) begin
        pipe_r[i] <= 10'h000;
      end
    end else begin
      conv_r <= conv_nxt;
      data_r <= data_nxt;
      oe_r <= oe_nxt;
      pipe_r <= pipe_nxt;
    end
  end

  assign DATA_O = data_r;
  assign DATA_OE_O = oe_r;

  chk_data_adc: assert property (conv_fall && !blk_r[BLK_OSEL_MSB]
    |=> DATA_O == $past(pipe_r[ADC_PIPE_DEPTH-1])) else $error("adc data not shown");
  chk_data_coarse: assert property (conv_fall && blk_r[9:8] == OSEL_COARSE
    |=> DATA_O == {$past(flag_r), $past(coarse_r)}) else $error("coarse view wrong");
  chk_data_fine: assert property (conv_fall && blk_r[9:8] == OSEL_FINE
    |=> DATA_O == {$past(flag_r), $past(fine_r)}) else $error("fine view wrong");
  chk_oe_follow: assert property (OE_N_I |=> !DATA_OE_O)
    else $error("data driven while output enable high");

  // black level averaging and offset correction
  ccdfe_cal_state_t state_r, state_nxt;
  logic [25:0] sum_r, sum_nxt;
  logic [7:0] pix_cnt_r, pix_cnt_nxt, pix_base, pix_target;
  logic [8:0] line_cnt_r, line_cnt_nxt, line_target;
  logic [2:0] pix_exp;
  logic [3:0] line_exp;
  logic [25:0] shifted;
  logic [19:0] third;
  logic [9:0] avg;
  logic signed [11:0] err, fine_new, coarse_new;
  logic [8:0] coarse_nxt, fine_nxt;
  logic flag_nxt, fine_auto, coarse_auto;

  function automatic logic signed [11:0] sm_to_s(input logic [8:0] v);
    sm_to_s = v[8] ? -$signed({4'h0, v[7:0]}) : $signed({4'h0, v[7:0]});
  endfunction

  function automatic logic [8:0] s_to_sm(input logic signed [11:0] v);
    logic signed [11:0] mag;
    mag = (v < 0) ? -v : v;
    s_to_sm = {v < 0, mag[7:0]};
  endfunction

  always_comb begin
    pix_exp = (blk_r[BLK_PIX_MSB:BLK_PIX_LSB] > PIX_EXP_MAX) ? PIX_EXP_MAX
      : blk_r[BLK_PIX_MSB:BLK_PIX_LSB];
    line_exp = (blk_r[BLK_LINE_MSB:BLK_LINE_LSB] > LINE_EXP_MAX) ? LINE_EXP_MAX
      : blk_r[BLK_LINE_MSB:BLK_LINE_LSB];
    pix_base = 8'h01 << pix_exp;
    pix_target = blk_r[BLK_TRIPLE] ? 8'(pix_base + (pix_base << 1)) : pix_base;
    line_target = 9'h001 << line_exp;
    shifted = sum_r >> (5'(pix_exp) + 5'(line_exp));
    third = shifted[11:0] * THIRD_MULT;
    avg = blk_r[BLK_TRIPLE] ? third[18:9] : shifted[9:0];
    err = $signed({2'b00, avg}) - $signed({2'b00, vb_r});
    fine_auto = !ctl_r[CTL_FINE_BYP];
    // coarse auto needs fine auto too, otherwise both are bypassed
    coarse_auto = fine_auto && !ctl_r[CTL_COARSE_BYP];
    fine_new = sm_to_s(fine_r) - err;
    coarse_new = sm_to_s(coarse_r);
    state_nxt = state_r;
    sum_nxt = sum_r;
    pix_cnt_nxt = pix_cnt_r;
    line_cnt_nxt = line_cnt_r;
    coarse_nxt = coarse_r;
    fine_nxt = fine_r;
    flag_nxt = flag_r;
    unique case (state_r)
      CAL_IDLE: begin
        pix_cnt_nxt = 8'h00;
        if (!BLACK_CAL_CLAMP_N_I) begin
          state_nxt = CAL_ACCUM;
        end
      end
      CAL_ACCUM: begin
        if (BLACK_CAL_CLAMP_N_I) begin
          line_cnt_nxt = line_cnt_r + 9'h001;
          state_nxt = (line_cnt_nxt == line_target) ? CAL_UPDATE : CAL_IDLE;
        end else if (conv_rise && pix_cnt_r < pix_target) begin
          sum_nxt = sum_r + 26'(ADC_SAMPLE_I);
          pix_cnt_nxt = pix_cnt_r + 8'h01;
        end
      end
      CAL_UPDATE: begin
        state_nxt = CAL_IDLE;
        sum_nxt = 26'h000_0000;
        line_cnt_nxt = 9'h000;
        if (fine_auto) begin
          flag_nxt = 1'b1;
          if (fine_new > OFFSET_MAG_MAX || fine_new < -OFFSET_MAG_MAX) begin
            // out of fine range: step coarse by one, park fine at its limit
            flag_nxt = 1'b0;
            if (coarse_auto && fine_new > 0 && coarse_new < OFFSET_MAG_MAX) begin
              coarse_nxt = s_to_sm(coarse_new + 12'sh001);
            end else if (coarse_auto && fine_new < 0 && coarse_new > -OFFSET_MAG_MAX) begin
              coarse_nxt = s_to_sm(coarse_new - 12'sh001);
            end
            fine_new = (fine_new > 0) ? OFFSET_MAG_MAX : -OFFSET_MAG_MAX;
          end
          fine_nxt = s_to_sm(fine_new);
        end
      end
      default: state_nxt = CAL_IDLE;
    endcase
    // direct writes seed the loop when auto mode is later re-enabled
    if (rx_wr && rx_addr == ADDR_COARSE) begin
      coarse_nxt = rx_data[8:0];
    end
    if (rx_wr && rx_addr == ADDR_FINE) begin
      fine_nxt = rx_data[8:0];
    end
    if (avg_clear || soft_rst) begin
      state_nxt = CAL_IDLE;
      sum_nxt = 26'h000_0000;
      line_cnt_nxt = 9'h000;
      pix_cnt_nxt = 8'h00;
    end
    if (soft_rst) begin
      coarse_nxt = OFFSET_RST;
      fine_nxt = OFFSET_RST;
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_r <= CAL_IDLE;
      sum_r <= 26'h000_0000;
      pix_cnt_r <= 8'h00;
      line_cnt_r <= 9'h000;
      coarse_r <= OFFSET_RST;
      fine_r <= OFFSET_RST;
      flag_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sum_r <= sum_nxt;
      pix_cnt_r <= pix_cnt_nxt;
      line_cnt_r <= line_cnt_nxt;
      coarse_r <= coarse_nxt;
      fine_r <= fine_nxt;
      flag_r <= flag_nxt;
    end
  end

  sequence s_line_end;
    state_r == CAL_ACCUM && BLACK_CAL_CLAMP_N_I && !avg_clear && !soft_rst;
  endsequence
  sequence s_update_done;
    state_r == CAL_UPDATE && !rx_wr ##1 state_r == CAL_IDLE;
  endsequence

  chk_clamp_start: assert property (state_r == CAL_IDLE && !BLACK_CAL_CLAMP_N_I && !rx_wr
    |=> state_r == CAL_ACCUM) else $error("clamp did not start averaging");
  chk_pixel_limit: assert property (pix_cnt_r <= pix_target && pix_target <= 8'hC0)
    else $error("pixel count past limit");
  chk_line_limit: assert property (s_line_end ##1 state_r == CAL_UPDATE
    |-> $past(line_cnt_r) + 9'h001 == line_target && line_target <= 9'h100)
    else $error("update not at line target");
  chk_update_clear: assert property (s_update_done |-> line_cnt_r == 9'h000 && sum_r == 0)
    else $error("averager not cleared after update");

  // decoded selects, registered so every pin comes from a flip-flop
  logic [16:0] sel_r, sel_nxt;

  always_comb begin
    sel_nxt[3:0] = test_r[TST_BIAS_MSB:TST_BIAS_LSB];
    sel_nxt[4] = test_r[TST_PIN_MSB];
    sel_nxt[5] = test_r[TST_PIN_MSB:TST_PIN_LSB] == TPIN_PGA;
    sel_nxt[6] = test_r[TST_EXT_REF];
    sel_nxt[7] = test_r[TST_MON_MSB];
    sel_nxt[8] = test_r[TST_MON_MSB:TST_MON_LSB] == MON_COARSE;
    sel_nxt[9] = ctl_r[CTL_STANDBY];
    sel_nxt[10] = ctl_r[CTL_UDAC1_PD];
    sel_nxt[11] = ctl_r[CTL_UDAC2_PD];
    sel_nxt[16:12] = 5'h00;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      sel_r <= 17'h0_0000;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  assign BIAS_CURRENT_CODE_O = sel_r[3:0];
  assign TEST_OUT_POS_OE_O = sel_r[4];
  assign TEST_OUT_NEG_OE_O = sel_r[4];
  assign TEST_OUT_PGA_SEL_O = sel_r[5];
  assign EXTERNAL_REFERENCE_SELECT_O = sel_r[6];
  assign OFFSET_MONITOR_PIN_OE_O = sel_r[7];
  assign OFFSET_MONITOR_COARSE_SEL_O = sel_r[8];
  assign STANDBY_O = sel_r[9];
  assign USER_DAC1_STANDBY_O = sel_r[10];
  assign USER_DAC2_STANDBY_O = sel_r[11];
  assign PGA_GAIN_CODE_O = gain_r;
  assign USER_DAC1_CODE_O = udac1_r;
  assign USER_DAC2_CODE_O = udac2_r;
  assign COARSE_OFFSET_O = coarse_r;
  assign FINE_OFFSET_O = fine_r;

  chk_test_decode: assert property (test_r[5:4] == TPIN_CLOCKS
    |=> TEST_OUT_POS_OE_O && !TEST_OUT_PGA_SEL_O) else $error("test pin select wrong");
  chk_monitor_hiz: assert property (!test_r[TST_MON_MSB] |=> !OFFSET_MONITOR_PIN_OE_O)
    else $error("monitor pin driven when off");
  chk_ref_select: assert property (test_r[TST_EXT_REF] |=> EXTERNAL_REFERENCE_SELECT_O)
    else $error("external reference not selected");
endmodule

// ==== rtl/ccdfe_pkg.sv ====
// constants for the ccd front end control block: serial frame, register map,
// field positions, reset values and converter timing.
// assumes a single core clock; the converter clock arrives as a sampled input.
package ccdfe_pkg;
  // serial frame
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;
  localparam logic [4:0] SER_OVERRUN = 5'h11;
  localparam int SER_ADDR_MSB = 13;
  localparam int SER_ADDR_LSB = 10;
  // register addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_GAIN = 4'h1;
  localparam logic [3:0] ADDR_UDAC1 = 4'h2;
  localparam logic [3:0] ADDR_UDAC2 = 4'h3;
  localparam logic [3:0] ADDR_COARSE = 4'h4;
  localparam logic [3:0] ADDR_FINE = 4'h5;
  localparam logic [3:0] ADDR_BLACK_TARGET = 4'h6;
  localparam logic [3:0] ADDR_BLACK_CAL = 4'h7;
  localparam logic [3:0] ADDR_TEST = 4'h8;
  // reset values
  localparam logic [9:0] BLACK_CAL_RST = 10'h003;
  localparam logic [9:0] TEST_RST = 10'h280;
  localparam logic [9:0] BLACK_TARGET_RST = 10'h040;
  localparam logic [9:0] CONTROL_RST = 10'h000;
  localparam logic [8:0] GAIN_RST = 9'h000;
  localparam logic [7:0] UDAC_RST = 8'h00;
  localparam logic [8:0] OFFSET_RST = 9'h000;
  // control fields
  localparam int CTL_STANDBY = 9;
  localparam int CTL_UDAC1_PD = 8;
  localparam int CTL_UDAC2_PD = 7;
  localparam int CTL_COARSE_BYP = 6;
  localparam int CTL_FINE_BYP = 5;
  localparam int CTL_AVG_CLEAR = 1;
  localparam int CTL_SOFT_RESET = 0;
  // black calibration fields
  localparam int BLK_OSEL_MSB = 9;
  localparam int BLK_OSEL_LSB = 8;
  localparam int BLK_LINE_MSB = 7;
  localparam int BLK_LINE_LSB = 4;
  localparam int BLK_TRIPLE = 3;
  localparam int BLK_PIX_MSB = 2;
  localparam int BLK_PIX_LSB = 0;
  // test fields
  localparam int TST_BIAS_MSB = 9;
  localparam int TST_BIAS_LSB = 6;
  localparam int TST_PIN_MSB = 5;
  localparam int TST_PIN_LSB = 4;
  localparam int TST_EXT_REF = 3;
  localparam int TST_RSVD = 2;
  localparam int TST_MON_MSB = 1;
  localparam int TST_MON_LSB = 0;
  // field codes
  localparam logic [1:0] OSEL_COARSE = 2'h2;
  localparam logic [1:0] OSEL_FINE = 2'h3;
  localparam logic [1:0] TPIN_CLOCKS = 2'h2;
  localparam logic [1:0] TPIN_PGA = 2'h3;
  localparam logic [1:0] MON_FINE = 2'h2;
  localparam logic [1:0] MON_COARSE = 2'h3;
  // limits
  localparam logic [3:0] LINE_EXP_MAX = 4'h8;
  localparam logic [2:0] PIX_EXP_MAX = 3'h6;
  localparam logic [8:0] GAIN_MAX = 9'h17F;
  localparam logic signed [11:0] OFFSET_MAG_MAX = 12'sh0FF;
  // one third approximated as 170/512, never above the true value
  localparam logic [7:0] THIRD_MULT = 8'hAA;
  // converter latency in half periods of the converter clock
  localparam int ADC_LATENCY_HALVES = 9;
  localparam int ADC_PIPE_DEPTH = (ADC_LATENCY_HALVES + 1) / 2;
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_ACCUM = 3'b010,
    CAL_UPDATE = 3'b100
  } ccdfe_cal_state_t;
endpackage

// ==== rtl/ccdfe_serial_rx.sv ====
// three-wire serial write receiver: 16-bit frames, address and data out.
// assumes sclk, serial_data_in and cs_n are already synchronous to clk_i.
module ccdfe_serial_rx
  import ccdfe_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  input wire logic cs_n_i,
  output logic wr_o,
  output logic [3:0] addr_o,
  output logic [9:0] data_o
);
  logic sclk_r;
  logic sclk_nxt;
  logic cs_n_r;
  logic cs_n_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic wr_r;
  logic wr_nxt;

  always_comb begin
    sclk_nxt = sclk_i;
    cs_n_nxt = cs_n_i;
    shift_nxt = shift_r;
    cnt_nxt = cnt_r;
    wr_nxt = 1'b0;
    if (cs_n_i) begin
      cnt_nxt = 5'h00;
      // commit only a frame of exactly sixteen bits, at chip select rise
      if (!cs_n_r && cnt_r == SER_FRAME_BITS) begin
        wr_nxt = 1'b1;
      end
    end else if (sclk_i && !sclk_r) begin
      shift_nxt = {shift_r[14:0], serial_data_in_i};
      if (cnt_r != SER_OVERRUN) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
      wr_r <= 1'b0;
    end else begin
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
    end
  end

  assign wr_o = wr_r;
  assign addr_o = shift_r[SER_ADDR_MSB:SER_ADDR_LSB];
  assign data_o = shift_r[9:0];
endmodule
